// >>> rtl/gpmc_ctrl.sv
`default_nettype none

module gpmc_ctrl (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Register port from the serial interface
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Gesture sequencer
    input wire logic swipe_entry_hit_i,
    input wire logic swipe_exit_hit_i,
    input wire logic conversion_busy_i,
    input wire logic pulse_start_i,
    // FIFO events
    input wire logic dataset_push_i,
    input wire logic dataset_pop_i,
    input wire logic [7:0] fifo_irq_threshold_i,
    // Engine status
    output logic swipe_engine_active_o,
    output logic up_down_en_o,
    output logic left_right_en_o,
    output logic double_rate_o,
    output logic fifo_flush_o,
    output logic [7:0] fifo_fill_count_o,
    output logic fifo_above_threshold_flag_o,
    output logic fifo_overflow_flag_o,
    output logic swipe_irq_flag_o,
    output logic irq_o,
    // LED driver
    output logic led_sink_pin_o,
    output logic pulse_busy_o,
    output logic pulse_done_o
);

    gpmc_pkg::gpmc_pulse_cfg_s pulse_cfg;
    logic [1:0] photodiode_pair_select;
    logic swipe_irq_unmask;
    logic exit_pending;

    logic wr_pulse;
    logic wr_dim;
    logic wr_mode;
    logic fifo_flush_cmd;
    logic mode_set;
    logic mode_clr;
    logic exit_req;
    logic next_active;
    logic next_exit_pending;
    logic fifo_full;
    logic push_ok;
    logic pop_ok;
    logic ovf_event;
    logic [7:0] next_fill;
    logic above_thr;
    logic next_valid;
    logic next_irq_flag;
    logic [1:0] next_pairs;
    logic [7:0] rd_mux;

    // Register decode
    assign wr_pulse = reg_wr_i && (reg_addr_i == gpmc_pkg::ADDR_PULSE_CFG);
    assign wr_dim = reg_wr_i && (reg_addr_i == gpmc_pkg::ADDR_DIM_SEL);
    assign wr_mode = reg_wr_i && (reg_addr_i == gpmc_pkg::ADDR_MODE_CTRL);
    assign fifo_flush_cmd = wr_mode && reg_wdata_i[gpmc_pkg::BIT_FLUSH];
    assign mode_set = wr_mode && reg_wdata_i[gpmc_pkg::BIT_MODE];
    assign mode_clr = wr_mode && !reg_wdata_i[gpmc_pkg::BIT_MODE];

    // Engine mode: entry is immediate, exit waits for the conversion
    assign exit_req = exit_pending || mode_clr || swipe_exit_hit_i;
    assign next_active = (mode_set || swipe_entry_hit_i) ? 1'b1 // RULE11
        : (exit_req && !conversion_busy_i) ? 1'b0 // RULE12
        : swipe_engine_active_o;
    assign next_exit_pending = next_active && !mode_set
        && !swipe_entry_hit_i && swipe_engine_active_o && exit_req;

    // FIFO level: a full FIFO refuses the dataset instead of overwriting
    assign fifo_full = (fifo_fill_count_o == gpmc_pkg::FIFO_DEPTH);
    assign pop_ok = dataset_pop_i && (fifo_fill_count_o != 8'h00)
        && !fifo_flush_cmd;
    assign push_ok = dataset_push_i
        && (fifo_flush_cmd || !fifo_full || pop_ok); // RULE14
    assign ovf_event = dataset_push_i && !push_ok; // RULE14
    assign next_fill = fifo_flush_cmd ? {7'h00, push_ok} // RULE8
        : fifo_fill_count_o + {7'h00, push_ok} - {7'h00, pop_ok};

    // A fresh event wins over a flush or a drain in the same cycle
    assign above_thr = (next_fill > fifo_irq_threshold_i);
    assign next_valid = above_thr || (fifo_above_threshold_flag_o // RULE13
        && !fifo_flush_cmd // RULE8
        && !(!next_active && next_fill == 8'h00)); // RULE13
    assign next_irq_flag = above_thr || (swipe_irq_flag_o
        && !fifo_flush_cmd // RULE8
        && next_fill != 8'h00);

    // Reserved bits are dropped on write and read back as zero
    assign next_pairs = gpmc_pkg::pair_enables(reg_wdata_i[1:0]); // RULE5

    assign rd_mux = (reg_addr_i == gpmc_pkg::ADDR_PULSE_CFG) ? pulse_cfg
        : (reg_addr_i == gpmc_pkg::ADDR_DIM_SEL) ?
            {6'h00, photodiode_pair_select}
        : (reg_addr_i == gpmc_pkg::ADDR_MODE_CTRL) ? // RULE10 RULE15
            {5'h00, 1'b0, swipe_irq_unmask, swipe_engine_active_o}
        : 8'h00;

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pulse_cfg <= gpmc_pkg::RST_PULSE_CFG; // RULE4
            photodiode_pair_select <= gpmc_pkg::RST_DIM_SEL;
            swipe_irq_unmask <= gpmc_pkg::RST_IRQ_UNMASK;
            up_down_en_o <= 1'b1;
            left_right_en_o <= 1'b1;
            double_rate_o <= 1'b0;
        end
        else
        begin
            if (wr_pulse)
            begin
                pulse_cfg <= reg_wdata_i;
            end
            if (wr_dim)
            begin
                photodiode_pair_select <= reg_wdata_i[1:0];
                up_down_en_o <= next_pairs[1]; // RULE5
                left_right_en_o <= next_pairs[0]; // RULE5
                double_rate_o <= (next_pairs != 2'b11); // RULE6
            end
            if (wr_mode)
            begin
                swipe_irq_unmask <= reg_wdata_i[gpmc_pkg::BIT_UNMASK];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            swipe_engine_active_o <= 1'b0;
            exit_pending <= 1'b0;
            fifo_flush_o <= 1'b0;
            fifo_fill_count_o <= 8'h00;
            fifo_above_threshold_flag_o <= 1'b0;
            fifo_overflow_flag_o <= 1'b0;
            swipe_irq_flag_o <= 1'b0;
            irq_o <= 1'b0;
            reg_rdata_o <= 8'h00;
        end
        else
        begin
            swipe_engine_active_o <= next_active;
            exit_pending <= next_exit_pending;
            fifo_flush_o <= fifo_flush_cmd; // RULE8 RULE15
            fifo_fill_count_o <= next_fill;
            fifo_above_threshold_flag_o <= next_valid;
            fifo_overflow_flag_o <= ovf_event
                || (fifo_overflow_flag_o && !fifo_flush_cmd); // RULE14 RULE8
            swipe_irq_flag_o <= next_irq_flag;
            irq_o <= swipe_irq_unmask && swipe_irq_flag_o; // RULE9
            if (reg_rd_i)
            begin
                reg_rdata_o <= rd_mux;
            end
        end
    end

    // Pulse trains only start while the engine is active
    gpmc_pulse_gen u_pulse_gen (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .start_i(pulse_start_i && swipe_engine_active_o),
        .cfg_i(pulse_cfg),
        .led_sink_o(led_sink_pin_o),
        .busy_o(pulse_busy_o),
        .done_o(pulse_done_o)
    );

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_flush_clears;
        fifo_flush_cmd && !dataset_push_i |=> fifo_fill_count_o == 8'h00
            && !fifo_above_threshold_flag_o && !fifo_overflow_flag_o
            && !swipe_irq_flag_o;
    endproperty
    a_flush_clears: assert property (p_flush_clears) // RULE8
        else $error("Flush left FIFO state behind");

    property p_flush_oneshot;
        fifo_flush_cmd ##1 !fifo_flush_cmd |=> !fifo_flush_o;
    endproperty
    a_flush_oneshot: assert property (p_flush_oneshot) // RULE15
        else $error("Flush command held beyond one write");

    property p_irq_masked;
        !swipe_irq_unmask [*2] |-> !irq_o;
    endproperty
    a_irq_masked: assert property (p_irq_masked) // RULE9
        else $error("Interrupt raised while masked");

    property p_irq_unmasked;
        swipe_irq_unmask && swipe_irq_flag_o |=> irq_o;
    endproperty
    a_irq_unmasked: assert property (p_irq_unmasked) // RULE9
        else $error("Unmasked gesture interrupt not raised");

    property p_mode_read;
        reg_rd_i && reg_addr_i == gpmc_pkg::ADDR_MODE_CTRL |=>
            reg_rdata_o[0] == $past(swipe_engine_active_o)
            && !reg_rdata_o[2];
    endproperty
    a_mode_read: assert property (p_mode_read) // RULE10
        else $error("Mode read back wrong");

    property p_enter_now;
        mode_set |=> swipe_engine_active_o;
    endproperty
    a_enter_now: assert property (p_enter_now) // RULE11
        else $error("Mode write of one did not enter engine");

    property p_exit_waits;
        swipe_engine_active_o && mode_clr && !swipe_entry_hit_i
            ##0 conversion_busy_i [*2] |-> swipe_engine_active_o;
    endproperty
    a_exit_waits: assert property (p_exit_waits) // RULE12
        else $error("Engine left during a conversion");

    property p_exit_done;
        swipe_engine_active_o && mode_clr && !swipe_entry_hit_i
            && !conversion_busy_i |=> !swipe_engine_active_o;
    endproperty
    a_exit_done: assert property (p_exit_done) // RULE12
        else $error("Engine did not leave after conversion");

    property p_valid_level;
        fifo_fill_count_o > $past(fifo_irq_threshold_i)
            |-> fifo_above_threshold_flag_o;
    endproperty
    a_valid_level: assert property (p_valid_level) // RULE13
        else $error("Valid flag missing above threshold");

    property p_overflow;
        dataset_push_i && fifo_full && !dataset_pop_i && !fifo_flush_cmd
            |=> fifo_overflow_flag_o
            && fifo_fill_count_o == gpmc_pkg::FIFO_DEPTH;
    endproperty
    a_overflow: assert property (p_overflow) // RULE14
        else $error("Overflow not flagged or dataset stored");

    property p_dims;
        wr_dim && reg_wdata_i[1:0] == gpmc_pkg::DIM_LR_ONLY |=>
            !up_down_en_o && left_right_en_o && double_rate_o;
    endproperty
    a_dims: assert property (p_dims) // RULE5 RULE6
        else $error("Pair select decode wrong");

endmodule

`default_nettype wire

// >>> rtl/gpmc_pkg.sv
// Behaviour
// (RULE1) Width field 0..3 gives 4/8/16/32 us on-time
// (RULE2) LED pin sinks current for selected width
// (RULE3) Pulse train length is count field plus one
// (RULE4) Pulse register resets to 0x40
// (RULE5) Pair select: 1 up-down, 2 left-right, else both
// (RULE6) Single pair runs double rate, other data invalid
// (RULE7) Host writes zero to reserved bits
// (RULE8) Flush empties FIFO and clears flags and level; a dataset pushed in the flush cycle is kept, leaving level one
// (RULE9) Interrupt unmask gates gesture interrupt output
// (RULE10) Mode bit reads one while engine runs
// (RULE11) Writing mode one enters engine at once
// (RULE12) Writing mode zero exits after conversion ends
// (RULE13) Valid flag above threshold, reset idle and empty
// (RULE14) Full FIFO drops new dataset, sets overflow
// (RULE15) Flush bit is one-shot, reads back zero
`default_nettype none

package gpmc_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_PULSE_CFG = 8'ha6;
    localparam logic [7:0] ADDR_DIM_SEL = 8'haa;
    localparam logic [7:0] ADDR_MODE_CTRL = 8'hab;

    // Reset values
    localparam logic [7:0] RST_PULSE_CFG = 8'h40;
    localparam logic [1:0] RST_DIM_SEL = 2'h0;
    localparam logic RST_IRQ_UNMASK = 1'b0;

    // Field positions
    localparam int unsigned BIT_FLUSH = 2;
    localparam int unsigned BIT_UNMASK = 1;
    localparam int unsigned BIT_MODE = 0;
    localparam logic [1:0] DIM_UD_ONLY = 2'h1;
    localparam logic [1:0] DIM_LR_ONLY = 2'h2;

    // Dataset capacity of the gesture FIFO
    localparam logic [7:0] FIFO_DEPTH = 8'h20;

    // Pulse timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned PULSE_4US_NS = 4000;
    localparam int unsigned PULSE_8US_NS = 8000;
    localparam int unsigned PULSE_16US_NS = 16000;
    localparam int unsigned PULSE_32US_NS = 32000;
    localparam int unsigned PULSE_GAP_NS = 4000;
    localparam logic [11:0] PULSE_4US_CYC = 12'(PULSE_4US_NS / CLK_PERIOD_NS);
    localparam logic [11:0] PULSE_8US_CYC = 12'(PULSE_8US_NS / CLK_PERIOD_NS);
    localparam logic [11:0] PULSE_16US_CYC =
        12'(PULSE_16US_NS / CLK_PERIOD_NS);
    localparam logic [11:0] PULSE_32US_CYC =
        12'(PULSE_32US_NS / CLK_PERIOD_NS);
    localparam logic [11:0] PULSE_GAP_CYC = 12'(PULSE_GAP_NS / CLK_PERIOD_NS);

    typedef struct packed {
        logic [1:0] pulse_width_select;
        logic [5:0] pulse_count_minus_one;
    } gpmc_pulse_cfg_s;

    typedef enum logic [1:0] {
        PS_IDLE = 2'b00,
        PS_ON = 2'b01,
        PS_OFF = 2'b10
    } gpmc_pulse_st_e;

    function automatic logic [11:0] pulse_on_cycles(input logic [1:0] sel);
        case (sel)
            2'h0: pulse_on_cycles = PULSE_4US_CYC;
            2'h1: pulse_on_cycles = PULSE_8US_CYC;
            2'h2: pulse_on_cycles = PULSE_16US_CYC;
            default: pulse_on_cycles = PULSE_32US_CYC;
        endcase
    endfunction

    // Returns {up_down_enable, left_right_enable}
    function automatic logic [1:0] pair_enables(input logic [1:0] sel);
        case (sel)
            DIM_UD_ONLY: pair_enables = 2'b10;
            DIM_LR_ONLY: pair_enables = 2'b01;
            default: pair_enables = 2'b11;
        endcase
    endfunction

endpackage

`default_nettype wire

// >>> rtl/gpmc_pulse_gen.sv
`default_nettype none

module gpmc_pulse_gen (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Train request
    input wire logic start_i,
    input wire gpmc_pkg::gpmc_pulse_cfg_s cfg_i,
    // LED driver
    output logic led_sink_o,
    output logic busy_o,
    output logic done_o
);

    gpmc_pkg::gpmc_pulse_st_e state;
    gpmc_pkg::gpmc_pulse_st_e next_state;
    gpmc_pkg::gpmc_pulse_cfg_s cfg_hold;
    gpmc_pkg::gpmc_pulse_cfg_s next_cfg_hold;
    logic [11:0] tmr;
    logic [11:0] next_tmr;
    logic [5:0] left;
    logic [5:0] next_left;
    logic next_led;
    logic next_done;
    logic tmr_zero;
    logic [11:0] on_cnt;
    logic [6:0] pulse_cnt;

    assign tmr_zero = (tmr == 12'h000);

    // Settings are latched at start so a host write cannot warp a train
    always_comb
    begin
        next_state = state;
        next_tmr = tmr;
        next_left = left;
        next_cfg_hold = cfg_hold;
        next_led = led_sink_o;
        next_done = 1'b0;
        case (state)
            gpmc_pkg::PS_IDLE:
            begin
                next_led = 1'b0;
                if (start_i)
                begin
                    next_cfg_hold = cfg_i;
                    next_left = cfg_i.pulse_count_minus_one; // RULE3
                    next_tmr = gpmc_pkg::pulse_on_cycles(
                        cfg_i.pulse_width_select) - 12'h001; // RULE1
                    next_led = 1'b1; // RULE2
                    next_state = gpmc_pkg::PS_ON;
                end
            end
            gpmc_pkg::PS_ON:
            begin
                if (tmr_zero)
                begin
                    next_led = 1'b0;
                    if (left == 6'h00)
                    begin
                        next_done = 1'b1;
                        next_state = gpmc_pkg::PS_IDLE;
                    end
                    else
                    begin
                        next_tmr = gpmc_pkg::PULSE_GAP_CYC - 12'h001;
                        next_state = gpmc_pkg::PS_OFF;
                    end
                end
                else
                begin
                    next_tmr = tmr - 12'h001;
                end
            end
            gpmc_pkg::PS_OFF:
            begin
                if (tmr_zero)
                begin
                    next_left = left - 6'h01; // RULE3
                    next_tmr = gpmc_pkg::pulse_on_cycles(
                        cfg_hold.pulse_width_select) - 12'h001; // RULE1
                    next_led = 1'b1; // RULE2
                    next_state = gpmc_pkg::PS_ON;
                end
                else
                begin
                    next_tmr = tmr - 12'h001;
                end
            end
            default:
            begin
                next_led = 1'b0;
                next_state = gpmc_pkg::PS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= gpmc_pkg::PS_IDLE;
            cfg_hold <= gpmc_pkg::RST_PULSE_CFG;
            tmr <= 12'h000;
            left <= 6'h00;
            led_sink_o <= 1'b0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cfg_hold <= next_cfg_hold;
            tmr <= next_tmr;
            left <= next_left;
            led_sink_o <= next_led;
            busy_o <= (next_state != gpmc_pkg::PS_IDLE);
            done_o <= next_done;
        end
    end

    // Helper counters read only by the checks below
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            on_cnt <= 12'h000;
            pulse_cnt <= 7'h00;
        end
        else
        begin
            on_cnt <= led_sink_o ? on_cnt + 12'h001 : 12'h000;
            if (next_led && !led_sink_o)
            begin
                pulse_cnt <= (state == gpmc_pkg::PS_IDLE) ? 7'h01
                    : pulse_cnt + 7'h01;
            end
        end
    end

    property p_on_width;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        $fell(led_sink_o) |->
            on_cnt == gpmc_pkg::pulse_on_cycles(cfg_hold.pulse_width_select);
    endproperty
    a_on_width: assert property (p_on_width) // RULE1
        else $error("Interval_a-time differs from selected width");

    property p_pulse_total;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        done_o |-> pulse_cnt == 7'({1'b0, cfg_hold.pulse_count_minus_one})
            + 7'h01;
    endproperty
    a_pulse_total: assert property (p_pulse_total) // RULE3
        else $error("Pulse train length is not count plus one");

    property p_led_in_train;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        led_sink_o |-> busy_o;
    endproperty
    a_led_in_train: assert property (p_led_in_train) // RULE2
        else $error("LED sinking outside a pulse train");

endmodule

`default_nettype wire

// >>> verification/gpmc_host_model.sv
`default_nettype none

module gpmc_host_model (
    // Requests from the bench
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] data_i,
    // Register port of the device
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] keep_mask;

    // Reserved bits leave the host as zero on every write
    assign keep_mask = (addr_i == gpmc_pkg::ADDR_DIM_SEL) ? 8'h03 :
        (addr_i == gpmc_pkg::ADDR_MODE_CTRL) ? 8'h07 : 8'hff;
    assign reg_wr_o = wr_i;
    assign reg_rd_o = rd_i;
    assign reg_addr_o = addr_i;
    // Idle data lines show garbage so a stale byte is never trusted
    assign reg_wdata_o = wr_i ? (data_i & keep_mask) : ~data_i;
endmodule

`default_nettype wire

// >>> verification/gpmc_ctrl_tb.sv
`default_nettype none
`define CHK(a, e, m) \
    begin \
        comparisons++; \
        if ((a) !== (e)) \
        begin \
            fail_count++; \
            $display("[ERR] %0t %s", $time, m); \
        end \
    end

module gpmc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic h_wr = 1'b0, h_rd = 1'b0;
    logic [7:0] h_addr = 8'h00, h_data = 8'h00, thr = 8'h00;
    logic entry_hit = 1'b0, exit_hit = 1'b0, conv_busy = 1'b0;
    logic pulse_start = 1'b0, push = 1'b0, pop = 1'b0;
    logic reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, d_rdata, d_lvl;
    logic d_act, d_ud, d_lr, d_dbl, d_flush, d_val, d_ov, d_irqf, d_irq;
    logic d_led, d_pdone, d_pbusy;
    logic [7:0] m_lvl, m_pcfg, m_rdata, n;
    logic [1:0] m_dim;
    logic m_act, m_pend, m_unm, m_val, m_ov, m_irqf, m_irq, m_flush;
    logic m_ud, m_lr, m_dbl, wr_ab;
    int fail_count = 0;
    int comparisons = 0;
    int seed = 3421;

    always #5 sys_clk_i = ~sys_clk_i;

    gpmc_host_model gpmc_host_model_i (.wr_i(h_wr), .rd_i(h_rd),
        .addr_i(h_addr), .data_i(h_data), .reg_wr_o(reg_wr),
        .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));

    gpmc_ctrl gpmc_ctrl_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_rdata_o(d_rdata),
        .swipe_entry_hit_i(entry_hit), .swipe_exit_hit_i(exit_hit),
        .conversion_busy_i(conv_busy), .pulse_start_i(pulse_start),
        .dataset_push_i(push), .dataset_pop_i(pop),
        .fifo_irq_threshold_i(thr), .swipe_engine_active_o(d_act),
        .up_down_en_o(d_ud), .left_right_en_o(d_lr), .double_rate_o(d_dbl),
        .fifo_flush_o(d_flush), .fifo_fill_count_o(d_lvl),
        .fifo_above_threshold_flag_o(d_val), .fifo_overflow_flag_o(d_ov),
        .swipe_irq_flag_o(d_irqf), .irq_o(d_irq), .led_sink_pin_o(d_led),
        .pulse_busy_o(d_pbusy), .pulse_done_o(d_pdone));

    // Reference model, updated on the same edges as the device
    always @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            {m_lvl, m_rdata, m_dim} = '0;
            {m_act, m_pend, m_unm, m_val, m_ov, m_irqf, m_irq} = '0;
            {m_flush, m_dbl} = '0;
            {m_ud, m_lr} = 2'b11;
            m_pcfg = 8'h40;
        end
        else
        begin
            wr_ab = reg_wr && reg_addr == gpmc_pkg::ADDR_MODE_CTRL;
            if (reg_rd)
                m_rdata = (reg_addr == gpmc_pkg::ADDR_PULSE_CFG) ? m_pcfg :
                    (reg_addr == gpmc_pkg::ADDR_DIM_SEL) ? {6'h00, m_dim} :
                    wr_ab | reg_addr == gpmc_pkg::ADDR_MODE_CTRL ?
                    {6'h00, m_unm, m_act} : 8'h00;
            m_irq = m_unm & m_irqf;
            m_flush = wr_ab && reg_wdata[2];
            // Mode settles first: the valid flag clears on the new mode
            if ((wr_ab && reg_wdata[0]) || entry_hit)
                {m_act, m_pend} = 2'b10;
            else if (m_act && (wr_ab || exit_hit || m_pend))
                {m_act, m_pend} = conv_busy ? 2'b11 : 2'b00;
            if (m_flush)
            begin
                n = push ? 8'h01 : 8'h00;
                {m_val, m_irqf, m_ov} = 3'b000;
            end
            else
            begin
                n = m_lvl;
                if (pop && n > 0)
                    n--;
                if (push && m_lvl == 8'h20 && !pop)
                    m_ov = 1'b1;
                else if (push)
                    n++;
            end
            if (n > thr)
                {m_val, m_irqf} = 2'b11;
            else
            begin
                if (!m_act && n == 0)
                    m_val = 1'b0;
                if (n == 0)
                    m_irqf = 1'b0;
            end
            m_lvl = n;
            if (wr_ab)
                m_unm = reg_wdata[1];
            if (reg_wr && reg_addr == gpmc_pkg::ADDR_PULSE_CFG)
                m_pcfg = reg_wdata;
            if (reg_wr && reg_addr == gpmc_pkg::ADDR_DIM_SEL)
            begin
                m_dim = reg_wdata[1:0];
                m_ud = m_dim != 2'h2;
                m_lr = m_dim != 2'h1;
                m_dbl = m_dim == 2'h1 || m_dim == 2'h2;
            end
        end
    end

    always @(negedge sys_clk_i)
    begin
        if (rst_n_i)
        begin
            `CHK(d_act, m_act, "mode")
            `CHK(d_ud, m_ud, "up-down pair")
            `CHK(d_lr, m_lr, "left-right pair")
            `CHK(d_dbl, m_dbl, "double rate")
            `CHK(d_flush, m_flush, "flush pulse")
            `CHK(d_lvl, m_lvl, "level")
            `CHK(d_val, m_val, "valid flag")
            `CHK(d_ov, m_ov, "overflow flag")
            `CHK(d_irqf, m_irqf, "irq flag")
            `CHK(d_irq, m_irq, "irq out")
        end
    end

    task automatic cyc(input int c);
        repeat (c) @(posedge sys_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1);
        h_wr <= 1'b1;
        h_addr <= a;
        h_data <= d;
        cyc(1);
        h_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        cyc(1);
        h_rd <= 1'b1;
        h_addr <= a;
        cyc(1);
        h_rd <= 1'b0;
        @(negedge sys_clk_i);
        `CHK(d_rdata, m_rdata, "read data")
    endtask

    task automatic conclude();
        if (fail_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Counts on-time of each LED pulse until the train reports done
    task automatic pulse_run(input logic [7:0] cfg);
        int hi;
        int np;
        int k;
        hi = 0;
        np = 0;
        k = 0;
        wr(gpmc_pkg::ADDR_PULSE_CFG, cfg);
        cyc(1);
        pulse_start <= 1'b1;
        cyc(1);
        pulse_start <= 1'b0;
        while (d_pdone !== 1'b1 && k < 60000)
        begin
            @(negedge sys_clk_i);
            k++;
            if (k == 1)
                `CHK(d_pbusy, 1'b1, "train busy")
            if (d_led === 1'b1)
                hi++;
            else if (hi > 0)
            begin
                `CHK(hi, 400 << cfg[7:6], "on time")
                np++;
                hi = 0;
            end
        end
        `CHK(np, cfg[5:0] + 1, "pulse count")
        `CHK(d_pbusy, 1'b0, "train idle")
        if (k >= 60000)
        begin
            fail_count++;
            conclude();
        end
    endtask

    initial
    begin
        cyc(1);
        thr <= 8'(($random(seed) & 7) + 2);
        cyc(3);
        rst_n_i <= 1'b1;
        rd(gpmc_pkg::ADDR_PULSE_CFG);
        rd(gpmc_pkg::ADDR_DIM_SEL);
        rd(gpmc_pkg::ADDR_MODE_CTRL);
        wr(8'ha7, 8'hff);
        rd(8'ha7);
        for (int d = 0; d < 4; d++)
        begin
            wr(gpmc_pkg::ADDR_DIM_SEL, 8'(d) | 8'hfc);
            rd(gpmc_pkg::ADDR_DIM_SEL);
        end
        // Entry and exit requests together: entry must win
        cyc(1);
        {entry_hit, exit_hit} <= 2'b11;
        cyc(1);
        {entry_hit, exit_hit, conv_busy} <= 3'b011;
        cyc(1);
        exit_hit <= 1'b0;
        cyc(4);
        conv_busy <= 1'b0;
        wr(gpmc_pkg::ADDR_MODE_CTRL, 8'h01);
        conv_busy <= 1'b1;
        wr(gpmc_pkg::ADDR_MODE_CTRL, 8'h02);
        rd(gpmc_pkg::ADDR_MODE_CTRL);
        cyc(3);
        conv_busy <= 1'b0;
        rd(gpmc_pkg::ADDR_MODE_CTRL);
        wr(gpmc_pkg::ADDR_MODE_CTRL, 8'h01);
        pulse_run(8'h3f);
        pulse_run(8'h40);
        pulse_run(8'h81);
        pulse_run(8'hc0);
        // Overfill with interrupts unmasked, then flush under a push
        wr(gpmc_pkg::ADDR_MODE_CTRL, 8'h03);
        for (int k = 0; k < 100; k++)
        begin
            cyc(1);
            push <= 1'b1;
            pop <= 1'($random(seed));
        end
        cyc(1);
        pop <= 1'b0;
        wr(gpmc_pkg::ADDR_MODE_CTRL, 8'h07);
        rd(gpmc_pkg::ADDR_MODE_CTRL);
        wr(gpmc_pkg::ADDR_MODE_CTRL, 8'h01);
        for (int k = 0; k < 100; k++)
        begin
            cyc(1);
            push <= 1'($random(seed));
            pop <= 1'b1;
        end
        cyc(1);
        {push, pop} <= 2'b00;
        wr(gpmc_pkg::ADDR_MODE_CTRL, 8'h00);
        // Flush with no dataset offered, engine already idle
        wr(gpmc_pkg::ADDR_MODE_CTRL, 8'h04);
        rd(gpmc_pkg::ADDR_MODE_CTRL);
        cyc(5);
        conclude();
    end
endmodule

`default_nettype wire
